// ===== design/oac_pkg.sv
// Shared constants for the on-screen-display attribute and colour block.
// Assumes a 32-bit APB bus with one register per aligned word.
package oac_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_DISPLAY_ATTRIBUTE_CONTROL = 8'h03;
    localparam logic [7:0] IDX_INT_FLAG = 8'h07;
    localparam logic [7:0] IDX_CLR_PTR = 8'h09;
    localparam logic [7:0] IDX_VRAM_ADDR = 8'h10;
    localparam logic [7:0] IDX_VRAM_DATA = 8'h11;
    localparam logic [7:0] IDX_MODE = 8'h12;
    localparam int ADDR_W = 10;

    // Display attribute fields
    localparam int ATTR_CHAR_EN = 7;
    localparam int ATTR_MBG_EN = 6;
    localparam int ATTR_FRINGE_EN = 5;
    localparam int ATTR_SMOOTH_OFF = 4;
    localparam int ATTR_POL_NEG = 3;
    localparam int ATTR_RGB_HI = 2;
    localparam logic [7:0] ATTR_RST = 8'h00;

    // Interrupt flag register fringe fields
    localparam int FRG_SEL = 7;
    localparam int FRG_RGB_HI = 6;
    localparam int FRG_RGB_LO = 4;
    localparam logic [7:0] INT_FLAG_RST = 8'h00;

    // Colour pointer register: upper nibble reads as ones
    localparam logic [3:0] CLR_PTR_RST = 4'h0;
    localparam logic [3:0] CLR_PTR_FILL = 4'hf;
    localparam int CLR_PTR_TOP = 3;

    // Video RAM entry: [11] code top, [10:8] palette, [7:0] code low
    localparam int VRAM_W = 12;
    localparam int VRAM_AW = 9;
    localparam int VRAM_DEPTH = 512;
    localparam int PAL_HI = 10;
    localparam int PAL_LO = 8;
    localparam int CODE_TOP = 11;
    localparam logic [8:0] SPACE_CODE = 9'h020;

    // Mode register
    localparam int MODE_PROG = 0;

    // 3-bit colours: red msb, green middle, blue lsb
    typedef enum logic [2:0] {
        OAC_BLACK = 3'h0,
        OAC_BLUE = 3'h1,
        OAC_GREEN = 3'h2,
        OAC_CYAN = 3'h3,
        OAC_RED = 3'h4,
        OAC_MAGENTA = 3'h5,
        OAC_YELLOW = 3'h6,
        OAC_WHITE = 3'h7
    } oac_colour_t;

    // APB slave phase
    typedef enum logic [1:0] {
        OAC_IDLE = 2'b01,
        OAC_WAIT = 2'b10
    } oac_apb_state_t;

endpackage

// ===== design/oac_vram.sv
// Video RAM for character entries: one write port, two registered reads.
// Assumes all ports on pclk; no reset on the array itself.
`timescale 1ns/100ps
`default_nettype none
module oac_vram
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [oac_pkg::VRAM_AW-1:0] waddr,
    input wire logic [oac_pkg::VRAM_W-1:0] wdata,
    input wire logic [oac_pkg::VRAM_AW-1:0] raddr_a,
    output logic [oac_pkg::VRAM_W-1:0] rdata_a_q,
    input wire logic [oac_pkg::VRAM_AW-1:0] raddr_b,
    output logic [oac_pkg::VRAM_W-1:0] rdata_b_q
);
    import oac_pkg::*;

    logic [VRAM_W-1:0] mem [VRAM_DEPTH];

    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk)
    begin
        rdata_a_q <= mem[raddr_a];
        rdata_b_q <= mem[raddr_b];
    end
endmodule // oac_vram
`default_nettype wire

// ===== design/oac_pixel.sv
// Per-pixel colour stage: fringe, smoothing, master background, polarity.
// Assumes colours already resolved from the palette by the renderer.
`timescale 1ns/100ps
`default_nettype none
module oac_pixel
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] attr,
    input wire logic [7:0] fringe_cfg,
    input wire logic progressive,
    input wire logic pix_valid,
    input wire logic in_char_area,
    input wire logic pix_fg,
    input wire logic [3:0] neigh_fg,
    input wire logic wide_char,
    input wire logic smooth_fill,
    input wire logic [2:0] fg_rgb,
    input wire logic [2:0] bg_rgb,
    input wire logic [2:0] video_rgb,
    output logic [2:0] rgb_q,
    output logic osd_active_q
);
    import oac_pkg::*;

    logic show_chars;
    logic smooth_on;
    logic fg_eff;
    logic fringe_on;
    logic is_fringe;
    logic [2:0] fringe_rgb;
    logic [2:0] screen_rgb;
    logic [2:0] pix_rgb;

    assign show_chars = attr[ATTR_CHAR_EN];
    // Smoothing is active-low and only for enlarged characters
    assign smooth_on = ~attr[ATTR_SMOOTH_OFF] & wide_char; // RL8
    // Bit value 1 is foreground, 0 background; disabled display is blank
    assign fg_eff = show_chars & (pix_fg | (smooth_on & smooth_fill)); // RL15 RL7
    assign fringe_on = attr[ATTR_FRINGE_EN] & ~progressive; // RL1 RL4
    assign is_fringe = fringe_on & show_chars & ~fg_eff & (|neigh_fg); // RL17
    assign fringe_rgb = fringe_cfg[FRG_SEL] ?
        fringe_cfg[FRG_RGB_HI:FRG_RGB_LO] : bg_rgb; // RL2
    // Master background replaces incoming video across the whole screen
    assign screen_rgb = attr[ATTR_MBG_EN] ?
        attr[ATTR_RGB_HI:0] : video_rgb; // RL6 RL10 RL5

    always_comb
    begin
        if (!in_char_area)
        begin
            pix_rgb = screen_rgb;
        end
        else if (fg_eff)
        begin
            pix_rgb = fg_rgb;
        end
        else if (is_fringe)
        begin
            pix_rgb = fringe_rgb;
        end
        else
        begin
            pix_rgb = bg_rgb;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rgb_q <= OAC_BLACK;
        end
        else if (pix_valid)
        begin
            // Negative polarity inverts every colour line
            rgb_q <= attr[ATTR_POL_NEG] ? ~pix_rgb : pix_rgb; // RL9 RL3
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osd_active_q <= 1'b0;
        end
        else if (pix_valid)
        begin
            osd_active_q <= in_char_area | attr[ATTR_MBG_EN];
        end
    end
endmodule // oac_pixel
`default_nettype wire

// ===== design/oac_top.sv
// Display attribute, fringe colour and video RAM write path with APB slave.
// Assumes a same-clock renderer supplying pixel bits and resolved colours;
// incoming broadcast video arrives from pins and is synchronised here.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RL1 - Fringe only while attribute bit 5 set
// RL2 - Fringe colour: background or programmed RGB
// RL3 - Colour codes red msb, blue lsb
// RL4 - No fringing in progressive scan mode
// RL5 - Attributes act on the whole screen
// RL6 - Master background replaces incoming video
// RL7 - Display disabled shows space characters
// RL8 - Smoothing for enlarged chars, low enables
// RL9 - Bit 3 inverts RGB output polarity
// RL10 - Master colour from attribute bits 2..0
// RL11 - Video RAM entries are twelve bits
// RL12 - Character write merges colour pointer bits
// RL13 - Palette bits index the colour table
// RL14 - Software rewrites code top with palette
// RL15 - Bitmap one foreground, zero background
// RL16 - Colour pointer four bits, upper ones
// RL17 - Background pixels adjoining foreground are fringe
// RL18 - Attribute writes affect later pixels only
module oac_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [oac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic pix_valid,
    input wire logic in_char_area,
    input wire logic [oac_pkg::VRAM_AW-1:0] cell_addr,
    input wire logic pix_fg,
    input wire logic [3:0] neigh_fg,
    input wire logic wide_char,
    input wire logic smooth_fill,
    input wire logic [2:0] fg_rgb,
    input wire logic [2:0] bg_rgb,
    input wire logic [2:0] video_rgb_pin,
    output logic [8:0] char_code_q,
    output logic [2:0] palette_idx_q,
    output logic [2:0] osd_rgb_q,
    output logic osd_active_q
);
    import oac_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] display_attribute_control_q;
    logic [7:0] interrupt_flag_register_q;
    logic [3:0] colour_pointer_register_q;
    logic [VRAM_AW-1:0] vram_addr_q;
    logic progressive_q;
    oac_apb_state_t apb_state_q;

    logic [7:0] reg_idx;
    logic addr_ok;
    logic idx_hit;
    logic commit;
    logic wr_commit;
    logic vram_we;
    logic [VRAM_W-1:0] vram_wdata;
    logic [VRAM_W-1:0] cpu_word;
    logic [VRAM_W-1:0] pix_word;
    logic [31:0] rd_mux;
    logic [2:0] video_s1_q;
    logic [2:0] video_s2_q;
    logic char_en_q;
    logic [2:0] osd_rgb_w;
    logic osd_active_w;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign reg_idx = paddr[ADDR_W-1:2];
    assign addr_ok = (paddr[1:0] == 2'b00);

    always_comb
    begin
        case (reg_idx)
            IDX_DISPLAY_ATTRIBUTE_CONTROL, IDX_INT_FLAG, IDX_CLR_PTR,
            IDX_VRAM_ADDR, IDX_VRAM_DATA, IDX_MODE:
                idx_hit = addr_ok;
            default:
                idx_hit = 1'b0;
        endcase
    end

    // One wait cycle per access gives the video RAM read time to land
    assign commit = psel & penable & pready_q;
    assign wr_commit = commit & pwrite & idx_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_state_q <= OAC_IDLE;
        end
        else
        begin
            case (apb_state_q)
                OAC_IDLE:
                    if (psel && penable)
                    begin
                        apb_state_q <= OAC_WAIT;
                    end
                OAC_WAIT:
                    apb_state_q <= OAC_IDLE;
                default:
                    apb_state_q <= OAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
        end
        else
        begin
            pready_q <= (apb_state_q == OAC_IDLE) & psel & penable;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            IDX_DISPLAY_ATTRIBUTE_CONTROL:
                rd_mux[7:0] = display_attribute_control_q;
            IDX_INT_FLAG:
                rd_mux[7:0] = interrupt_flag_register_q;
            IDX_CLR_PTR:
                rd_mux[7:0] = {CLR_PTR_FILL, colour_pointer_register_q}; // RL16
            IDX_VRAM_ADDR:
                rd_mux[VRAM_AW-1:0] = vram_addr_q;
            IDX_VRAM_DATA:
                rd_mux[VRAM_W-1:0] = cpu_word;
            IDX_MODE:
                rd_mux[MODE_PROG] = progressive_q;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if ((apb_state_q == OAC_IDLE) && psel && penable)
        begin
            // Refused accesses read as zero
            prdata_q <= (pwrite || !idx_hit) ? 32'h0000_0000 : rd_mux;
            pslverr_q <= ~idx_hit;
        end
    end

    // ----------------------------------------------------------------
    // Control registers; writes land at the access edge only
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            display_attribute_control_q <= ATTR_RST;
        end
        else if (wr_commit && reg_idx == IDX_DISPLAY_ATTRIBUTE_CONTROL)
        begin
            display_attribute_control_q <= pwdata[7:0]; // RL18
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_flag_register_q <= INT_FLAG_RST;
        end
        else if (wr_commit && reg_idx == IDX_INT_FLAG)
        begin
            // Only the fringe fields are held here; low nibble reads zero
            interrupt_flag_register_q <= {pwdata[7:4], 4'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            colour_pointer_register_q <= CLR_PTR_RST;
        end
        else if (wr_commit && reg_idx == IDX_CLR_PTR)
        begin
            colour_pointer_register_q <= pwdata[3:0]; // RL16
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vram_addr_q <= '0;
        end
        else if (wr_commit && reg_idx == IDX_VRAM_ADDR)
        begin
            vram_addr_q <= pwdata[VRAM_AW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            progressive_q <= 1'b0;
        end
        else if (wr_commit && reg_idx == IDX_MODE)
        begin
            progressive_q <= pwdata[MODE_PROG];
        end
    end

    // ----------------------------------------------------------------
    // Video RAM write path
    // ----------------------------------------------------------------
    // A character byte write carries the colour pointer along with it,
    // so code top bit and palette always change together
    assign vram_we = wr_commit & (reg_idx == IDX_VRAM_DATA); // RL14
    assign vram_wdata = {colour_pointer_register_q[CLR_PTR_TOP],
                         colour_pointer_register_q[2:0],
                         pwdata[7:0]}; // RL12 RL11

    oac_vram u_vram
    (
        .pclk(pclk),
        .we(vram_we),
        .waddr(vram_addr_q),
        .wdata(vram_wdata),
        .raddr_a(vram_addr_q),
        .rdata_a_q(cpu_word),
        .raddr_b(cell_addr),
        .rdata_b_q(pix_word)
    );

    // ----------------------------------------------------------------
    // Character fetch toward the generator and palette
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            char_en_q <= 1'b0;
        end
        else
        begin
            char_en_q <= display_attribute_control_q[ATTR_CHAR_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            char_code_q <= SPACE_CODE;
            palette_idx_q <= 3'h0;
        end
        else
        begin
            // Disabled display fetches spaces; row colours still apply
            char_code_q <= char_en_q ?
                {pix_word[CODE_TOP], pix_word[7:0]} : SPACE_CODE; // RL7
            palette_idx_q <= pix_word[PAL_HI:PAL_LO]; // RL13
        end
    end

    // ----------------------------------------------------------------
    // Incoming video synchroniser and colour stage
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            video_s1_q <= 3'h0;
            video_s2_q <= 3'h0;
        end
        else
        begin
            video_s1_q <= video_rgb_pin;
            video_s2_q <= video_s1_q;
        end
    end

    oac_pixel u_pixel
    (
        .pclk(pclk),
        .presetn(presetn),
        .attr(display_attribute_control_q),
        .fringe_cfg(interrupt_flag_register_q),
        .progressive(progressive_q),
        .pix_valid(pix_valid),
        .in_char_area(in_char_area),
        .pix_fg(pix_fg),
        .neigh_fg(neigh_fg),
        .wide_char(wide_char),
        .smooth_fill(smooth_fill),
        .fg_rgb(fg_rgb),
        .bg_rgb(bg_rgb),
        .video_rgb(video_s2_q),
        .rgb_q(osd_rgb_w),
        .osd_active_q(osd_active_w)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osd_rgb_q <= 3'h0;
            osd_active_q <= 1'b0;
        end
        else
        begin
            osd_rgb_q <= osd_rgb_w; // RL5
            osd_active_q <= osd_active_w;
        end
    end
endmodule // oac_top
`default_nettype wire

// ===== tb/oac_top_props.sv
// Assertion checker for the attribute, colour and video RAM block's ports.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module oac_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [oac_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_q,
    input wire logic pready_q,
    input wire logic pslverr_q,
    input wire logic pix_valid,
    input wire logic in_char_area,
    input wire logic pix_fg,
    input wire logic wide_char,
    input wire logic smooth_fill,
    input wire logic [2:0] fg_rgb,
    input wire logic [2:0] bg_rgb,
    input wire logic [2:0] osd_rgb_q
);
    import oac_pkg::*;
    logic [7:0] attr_sh_q;
    logic mapped;
    logic [2:0] pol3;
    logic [2:0] mbg_c;
    logic [2:0] fg_c;
    logic [2:0] bg_c;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    assign mapped = paddr inside {10'h00c, 10'h01c, 10'h024, 10'h040,
                                  10'h044, 10'h048};
    assign pol3 = {3{attr_sh_q[3]}};
    assign mbg_c = attr_sh_q[2:0] ^ pol3;
    assign fg_c = fg_rgb ^ pol3;
    assign bg_c = bg_rgb ^ pol3;
    // Mirror of the attribute register, updated on completed writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            attr_sh_q <= 8'h00;
        else if (psel && penable && pready_q && pwrite && paddr == 10'h00c)
            attr_sh_q <= pwdata[7:0];
    end
    property p_rdy_pulse;
        pready_q |=> !pready_q;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
    property p_rdy_time;
        psel && $rose(penable) |=> pready_q;
    endproperty
    a_rdy_time: assert property (p_rdy_time) else $error("ready late");
    property p_map_ok;
        pready_q && mapped |-> !pslverr_q;
    endproperty
    a_map_ok: assert property (p_map_ok) else $error("error on mapped");
    property p_map_err;
        pready_q && !mapped |-> pslverr_q && (pwrite || prdata_q == 32'h0);
    endproperty
    a_map_err: assert property (p_map_err) else $error("unmapped accepted");
    property p_ptr_ones;
        pready_q && !pwrite && paddr == 10'h024 |-> prdata_q[7:4] == 4'hf;
    endproperty
    a_ptr_ones: assert property (p_ptr_ones) else $error("pointer top");
    property p_attr_rd;
        pready_q && !pwrite && paddr == 10'h00c |-> prdata_q[7:0] == attr_sh_q;
    endproperty
    a_attr_rd: assert property (p_attr_rd) else $error("attribute read");
    property p_mbg;
        pix_valid && !in_char_area && attr_sh_q[6]
            |-> ##2 osd_rgb_q == $past(mbg_c, 2);
    endproperty
    a_mbg: assert property (p_mbg) else $error("master colour");
    property p_fg;
        pix_valid && in_char_area && pix_fg && attr_sh_q[7]
            |-> ##2 osd_rgb_q == $past(fg_c, 2);
    endproperty
    a_fg: assert property (p_fg) else $error("foreground colour");
    property p_bg;
        pix_valid && in_char_area && (!attr_sh_q[7] || (!pix_fg
            && !attr_sh_q[5] && !(wide_char && smooth_fill && !attr_sh_q[4])))
            |-> ##2 osd_rgb_q == $past(bg_c, 2);
    endproperty
    a_bg: assert property (p_bg) else $error("background colour");
    c_wr_attr: cover property (pready_q && pwrite && paddr == 10'h00c);
    c_err: cover property (pslverr_q);
    c_fringe: cover property (pix_valid && in_char_area && !pix_fg
                              && attr_sh_q[5] && attr_sh_q[7]);
endmodule // oac_chk
bind oac_top oac_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .pix_valid(pix_valid), .in_char_area(in_char_area), .pix_fg(pix_fg),
    .wide_char(wide_char), .smooth_fill(smooth_fill),
    .fg_rgb(fg_rgb), .bg_rgb(bg_rgb), .osd_rgb_q(osd_rgb_q));
`default_nettype wire

// ===== tb/oac_tv_src.sv
// Broadcast video source feeding the block's incoming video pins.
// Assumes nothing of the block's clock: the pins change asynchronously.
`timescale 1ns/100ps
`default_nettype none
module oac_tv_src
(
    input wire logic [2:0] colour,
    output logic [2:0] video_rgb_pin
);
    // Changes land off the clock grid, as a real tuner's would
    always @(colour)
        video_rgb_pin <= #1.3 colour;
endmodule // oac_tv_src
`default_nettype wire

// ===== tb/oac_tb_top.sv
// Self-checking bench for the attribute, colour and video RAM block.
// Assumes the block answers APB in its own time and pixels after 2 cycles.
`timescale 1ns/100ps
`default_nettype none
module osd_display_attribute_color_tb_top;
    import oac_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic pix_valid = 1'b0;
    logic in_char_area = 1'b0;
    logic [8:0] cell_addr = 9'h000;
    logic pix_fg = 1'b0;
    logic [3:0] neigh_fg = 4'h0;
    logic wide_char = 1'b0;
    logic smooth_fill = 1'b0;
    logic osd_active_q;
    logic [2:0] fg_rgb = 3'h6;
    logic [2:0] bg_rgb = 3'h1;
    logic [2:0] tv_colour = 3'h0;
    logic [2:0] video_rgb_pin;
    logic [8:0] char_code_q;
    logic [2:0] palette_idx_q;
    logic [2:0] osd_rgb_q;
    int error_cnt = 0;
    int checks_done = 0;
    always #2.5 pclk = ~pclk;
    oac_tv_src u_tv (.colour(tv_colour), .video_rgb_pin(video_rgb_pin));
    oac_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .pix_valid(pix_valid), .in_char_area(in_char_area),
        .cell_addr(cell_addr), .pix_fg(pix_fg), .neigh_fg(neigh_fg),
        .wide_char(wide_char), .smooth_fill(smooth_fill), .fg_rgb(fg_rgb),
        .bg_rgb(bg_rgb), .video_rgb_pin(video_rgb_pin),
        .char_code_q(char_code_q), .palette_idx_q(palette_idx_q),
        .osd_rgb_q(osd_rgb_q), .osd_active_q(osd_active_q));
    // --------------------------------------------------------------
    // Common tasks
    // --------------------------------------------------------------
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                       output logic [11:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready_q !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
        begin
            error_cnt++;
            $display("ERROR t=%0t bus answer missing", $time);
            end_of_test();
        end
        rd = prdata_q[11:0];
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [11:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [11:0] x,
                       input logic xe);
        logic [11:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(r, x);
        check({11'h000, e}, {11'h000, xe});
    endtask
    task automatic px(input logic ar, input logic fg, input logic [3:0] nb,
                      input logic [2:0] x);
        pix_valid <= 1'b1;
        in_char_area <= ar;
        pix_fg <= fg;
        neigh_fg <= nb;
        @(posedge pclk);
        pix_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check({9'h000, osd_rgb_q}, {9'h000, x});
        @(posedge pclk);
    endtask
    task automatic fetch(input logic [8:0] a, input logic [8:0] code,
                         input logic [2:0] pal, input logic pal_chk);
        cell_addr <= a;
        repeat (3) @(posedge pclk);
        #1;
        check({3'h0, char_code_q}, {3'h0, code});
        if (pal_chk)
            check({9'h000, palette_idx_q}, {9'h000, pal});
        @(posedge pclk);
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_regs;
        rdc(10'h00c, 12'h000, 1'b0);
        rdc(10'h024, 12'h0f0, 1'b0);
        rdc(10'h3fc, 12'h000, 1'b1);
        wr(10'h00d, 8'hff);
        rdc(10'h00d, 12'h000, 1'b1);
        rdc(10'h00c, 12'h000, 1'b0);
        wr(10'h00c, 8'h5a);
        rdc(10'h00c, 12'h05a, 1'b0);
        wr(10'h024, 8'h3a);
        rdc(10'h024, 12'h0fa, 1'b0);
    endtask
    task automatic t_vram;
        wr(10'h024, 8'h0d);
        wr(10'h040, 8'h05);
        wr(10'h044, 8'ha5);
        rdc(10'h044, 12'hda5, 1'b0);
        wr(10'h024, 8'h02);
        wr(10'h040, 8'h06);
        wr(10'h044, 8'h3c);
        rdc(10'h044, 12'h23c, 1'b0);
        wr(10'h00c, 8'h00);
        fetch(9'h005, 9'h020, 3'h0, 1'b0);
        wr(10'h00c, 8'h80);
        fetch(9'h005, 9'h1a5, 3'h5, 1'b1);
        fetch(9'h006, 9'h03c, 3'h2, 1'b1);
        wr(10'h00c, 8'hff);
        rdc(10'h044, 12'h23c, 1'b0);
    endtask
    task automatic t_mbg;
        logic [3:0] c;
        tv_colour <= 3'h5;
        wr(10'h00c, 8'h00);
        px(1'b0, 1'b0, 4'h0, 3'h5);
        check({11'h000, osd_active_q}, 12'h000);
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            wr(10'h00c, {4'h4, c});
            px(1'b0, 1'b0, 4'h0, c[2:0] ^ {3{c[3]}});
            check({11'h000, osd_active_q}, 12'h001);
        end
    endtask
    task automatic t_fringe;
        wr(10'h00c, 8'ha0);
        wr(10'h01c, 8'h00);
        px(1'b1, 1'b0, 4'h2, 3'h1);
        wr(10'h01c, 8'hb0);
        rdc(10'h01c, 12'h0b0, 1'b0);
        px(1'b1, 1'b0, 4'h2, 3'h3);
        px(1'b1, 1'b0, 4'h0, 3'h1);
        px(1'b1, 1'b1, 4'h2, 3'h6);
        wr(10'h048, 8'h01);
        px(1'b1, 1'b0, 4'h2, 3'h1);
        wr(10'h048, 8'h00);
        px(1'b1, 1'b0, 4'h8, 3'h3);
        wr(10'h00c, 8'h80);
        px(1'b1, 1'b0, 4'h2, 3'h1);
        wide_char <= 1'b1;
        smooth_fill <= 1'b1;
        px(1'b1, 1'b0, 4'h0, 3'h6);
        wide_char <= 1'b0;
        px(1'b1, 1'b0, 4'h0, 3'h1);
        wide_char <= 1'b1;
        wr(10'h00c, 8'h90);
        px(1'b1, 1'b0, 4'h0, 3'h1);
        wide_char <= 1'b0;
        smooth_fill <= 1'b0;
        wr(10'h00c, 8'h20);
        px(1'b1, 1'b1, 4'h2, 3'h1);
        wr(10'h00c, 8'ha8);
        px(1'b1, 1'b0, 4'h4, 3'h4);
    endtask
    task automatic t_rst;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check({3'h0, char_code_q}, {3'h0, SPACE_CODE});
        check({9'h000, osd_rgb_q}, 12'h000);
        @(posedge pclk);
        rdc(10'h024, 12'h0f0, 1'b0);
        rdc(10'h00c, 12'h000, 1'b0);
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_vram();
        t_mbg();
        t_fringe();
        t_rst();
        end_of_test();
    end
endmodule // osd_display_attribute_color_tb_top
`default_nettype wire
